// *** bench/tss_line_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tss_line_model (
    // bench side
    input wire logic clk,
    input wire logic [24:0] lineSet,
    input wire logic [11:0] smpSet,
    // device side
    output logic [24:0] lines = 25'h0,
    output logic [11:0] term0 = 12'h0,
    output logic [11:0] term1 = 12'h0,
    output logic [11:0] pga = 12'h0
);
    // ****************
    // far-side sources
    // ****************
    always @(posedge clk)
    begin
        lines <= lineSet;
        term0 <= smpSet;
        term1 <= ~smpSet;
        pga <= smpSet;
    end
endmodule // tss_line_model
`default_nettype wire

// *** bench/tss_trigger_select_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tss_defs.vh"
module tss_trigger_select_asserts (
    // clock and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // trigger lines
    input wire logic [15:0] pfLineIn,
    input wire logic [7:0] stbLineIn,
    input wire logic starTrigIn,
    // outputs
    input wire logic [2:0] muxChan_q,
    input wire logic muxHold_q,
    input wire logic aiTrig_q,
    input wire logic aoTrig_q,
    input wire logic ctrTrig_q,
    input wire logic dwaveTrig_q,
    input wire logic cmpEvent_q,
    input wire logic [4:0] cmpAction_q,
    input wire logic [15:0] pfLineOut_q,
    input wire logic [7:0] stbLineOut_q
);
    // ****************
    // register shadows
    // ****************
    logic [31:0] dsel_q;
    logic [31:0] act_q;
    logic selLine;
    logic [3:0] trigs;
    assign trigs = {dwaveTrig_q, ctrTrig_q, aoTrig_q, aiTrig_q};
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dsel_q <= 32'h0;
            act_q <= 32'h0;
        end
        else if (avs_write && !avs_waitrequest)
        begin
            if (avs_address == `TSS_OFF_DSEL)
                dsel_q <= avs_writedata;
            if (avs_address == `TSS_OFF_ACTION)
                act_q <= avs_writedata;
        end
    end
    always_comb
    begin
        if (dsel_q[4])
            selLine = dsel_q[3] ? starTrigIn : stbLineIn[dsel_q[2:0]];
        else
            selLine = pfLineIn[dsel_q[3:0]];
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    AST_WAIT_ONE:
        assert property ((avs_read || avs_write) && avs_waitrequest
            |=> !avs_waitrequest) else $error("bus answer late");
    AST_WAIT_PULSE:
        assert property (!avs_waitrequest |=> avs_waitrequest)
            else $error("wait low too long");
    AST_WAIT_IDLE:
        assert property (!(avs_read || avs_write) && avs_waitrequest
            |=> avs_waitrequest) else $error("answer without request");
    AST_TRIG_LAT:
        assert property (dsel_q[9] && dsel_q[4:0] <= 5'd24 &&
            (dsel_q[8] ? $fell(selLine) : $rose(selLine))
            |-> ##3 trigs == act_q[3:0]) else $error("trigger pulse wrong");
    AST_TRIG_WIDTH:
        assert property (trigs != 4'h0 |=> trigs == 4'h0)
            else $error("trigger pulse too wide");
    AST_ROUTE_LVL:
        assert property (pfLineOut_q == {16{cmpEvent_q}} &&
            stbLineOut_q == {8{cmpEvent_q}}) else $error("route mismatch");
    AST_CMP_ACT:
        assert property (cmpAction_q != 5'h0 |-> cmpEvent_q &&
            (cmpAction_q & ~act_q[12:8]) == 5'h0)
            else $error("comparison action wrong");
    AST_MUX_HOLD:
        assert property (muxHold_q ##1 muxHold_q |-> $stable(muxChan_q))
            else $error("mux moved while holding");
endmodule // tss_trigger_select_asserts
bind tss_trigger_select tss_trigger_select_asserts chk (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .pfLineIn(pfLineIn), .stbLineIn(stbLineIn), .starTrigIn(starTrigIn),
    .muxChan_q(muxChan_q), .muxHold_q(muxHold_q), .aiTrig_q(aiTrig_q),
    .aoTrig_q(aoTrig_q), .ctrTrig_q(ctrTrig_q), .dwaveTrig_q(dwaveTrig_q),
    .cmpEvent_q(cmpEvent_q), .cmpAction_q(cmpAction_q),
    .pfLineOut_q(pfLineOut_q), .stbLineOut_q(stbLineOut_q)
);
`default_nettype wire

// *** bench/tss_trigger_select_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tss_defs.vh"
module tss_trigger_select_test;
    // ****************
    // signals
    // ****************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [4:0] avs_address = 5'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [24:0] lineSet = 25'h0;
    logic [24:0] lines;
    logic [11:0] smpSet = 12'h0;
    logic [11:0] term0, term1, pga;
    logic [2:0] muxChanReq = 3'h0;
    logic [2:0] muxChan_q;
    logic muxHold_q, ai, ao, ctr, dw, cmp, fall, en;
    logic [4:0] cmpAct, src;
    logic [15:0] pfOut, pfOe;
    logic [7:0] stbOut, stbOe;
    logic [3:0] act;
    logic [23:0] route;
    logic [31:0] rdExp[$];
    logic [3:0] trExp[$];
    int errorCnt = 0;
    int checks = 0;
    integer seed = 32'h78b6e59b;
    logic [11:0] smp[3][4] = '{'{12'h400, 12'h900, 12'h050, 12'h400},
        '{12'h600, 12'h900, 12'h750, 12'h600},
        '{12'ha00, 12'h700, 12'h850, 12'ha00}};
    logic [3:0] expBits[6] = '{4'hd, 4'h2, 4'h6, 4'h6, 4'h9, 4'h6};
    int setOf[6] = '{0, 0, 1, 2, 0, 0};
    logic [4:0] adr[8] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h14, 5'h18,
        5'h02, 5'h1e};
    logic [4:0] srcTab[3] = '{5'd24, 5'd15, 5'd23};

    always #2 ref_clk = ~ref_clk;

    tss_trigger_select #(.SW(12), .NCH(8), .SIMUL(0)) dut (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pfLineIn(lines[15:0]),
        .stbLineIn(lines[23:16]), .starTrigIn(lines[24]),
        .afTerm0Sample(term0), .afTerm1Sample(term1), .pgaSample(pga),
        .aiSimSamples(96'h0), .muxChanReq(muxChanReq),
        .muxChan_q(muxChan_q), .muxHold_q(muxHold_q), .aiTrig_q(ai),
        .aoTrig_q(ao), .ctrTrig_q(ctr), .dwaveTrig_q(dw),
        .cmpEvent_q(cmp), .cmpAction_q(cmpAct), .pfLineOut_q(pfOut),
        .pfLineOe_q(pfOe), .stbLineOut_q(stbOut), .stbLineOe_q(stbOe)
    );
    tss_line_model far (.clk(ref_clk), .lineSet(lineSet),
        .smpSet(smpSet), .lines(lines), .term0(term0), .term1(term1),
        .pga(pga));

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            errorCnt++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask

    task finishTest;
        if (errorCnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // request held until waitrequest is seen low
    task bus(input logic r, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= r;
        avs_write <= !r;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask

    task rd(input logic [4:0] a, input logic [31:0] e);
        rdExp.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask

    task ana(input logic [11:0] s, input logic e);
        smpSet <= s;
        repeat (4) @(posedge ref_clk);
        check("cmp", {31'h0, cmp}, {31'h0, e});
        check("cmpAction", {27'h0, cmpAct}, e ? 32'h15 : 32'h0);
        check("lineOut", {8'h0, stbOut, pfOut}, {8'h0, {24{e}}});
        check("lineOe", {8'h0, stbOe, pfOe}, {8'h0, route});
    endtask

    always @(posedge ref_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            check("readdata", avs_readdata,
                rdExp.size() > 0 ? rdExp.pop_front() : 32'hx);
        if ({dw, ctr, ao, ai} !== 4'h0)
            check("trigger", {28'h0, dw, ctr, ao, ai},
                {28'h0, trExp.size() > 0 ? trExp.pop_front() : 4'h0});
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errorCnt++;
        finishTest;
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        wr(5'h02, 32'hffffffff);
        foreach (adr[i])
            rd(adr[i], {31'h0, adr[i] == `TSS_OFF_SCAN});
        route = 24'($random(seed));
        wr(`TSS_OFF_ROUTE, {8'h0, route});
        rd(`TSS_OFF_ROUTE, {8'h0, route});
        for (int i = 0; i < 12; i++)
        begin
            src = i < 3 ? srcTab[i] : 5'($unsigned($random(seed)) % 25);
            act = 4'($random(seed));
            fall = i[0];
            en = i != 5;
            wr(`TSS_OFF_DSEL, 32'h0);
            lineSet[src] <= fall;
            wr(`TSS_OFF_ACTION, {19'h0, 5'h15, 4'h0, act});
            wr(`TSS_OFF_DSEL, {22'h0, en, fall, 3'h0, src});
            repeat (4) @(posedge ref_clk);
            if (en && act != 4'h0)
                trExp.push_back(act);
            lineSet[src] <= !fall;
            repeat (8) @(posedge ref_clk);
            lineSet[src] <= 1'b0;
            repeat (8) @(posedge ref_clk);
        end
        wr(`TSS_OFF_ACTION, 32'h150f);
        trExp.push_back(4'hf);
        wr(`TSS_OFF_CMD, 32'h1);
        rd(`TSS_OFF_CMD, 32'h0);
        wr(`TSS_OFF_LEVEL, 32'h0100_0800);
        for (int m = 0; m < 6; m++)
        begin
            src = 5'(m % 3);
            wr(`TSS_OFF_ASEL, {15'h0, 1'b1, 5'h0, 3'(m), 8'(src)});
            for (int k = 0; k < 4; k++)
                ana(src == 5'd1 ? ~smp[setOf[m]][k] : smp[setOf[m]][k],
                    expBits[m][k]);
        end
        wr(`TSS_OFF_SCAN, 32'h0301);
        wr(`TSS_OFF_ASEL, 32'h1_0102);
        ana(12'h900, 1'b0);
        rd(`TSS_OFF_STATUS, 32'h1c);
        wr(`TSS_OFF_CMD, 32'h2);
        rd(`TSS_OFF_STATUS, 32'h4);
        wr(`TSS_OFF_SCAN, 32'h2);
        wr(`TSS_OFF_ASEL, 32'h1_1102);
        ana(12'h900, 1'b0);
        wr(`TSS_OFF_ASEL, 32'h1_0102);
        ana(12'h900, 1'b1);
        ana(12'h400, 1'b0);
        wr(`TSS_OFF_SCAN, 32'h0501);
        wr(`TSS_OFF_ASEL, 32'h1_0152);
        for (int k = 0; k < 6; k++)
        begin
            muxChanReq <= 3'($random(seed));
            repeat (2) @(posedge ref_clk);
            check("muxHeld", {28'h0, muxHold_q, muxChan_q}, 32'hd);
        end
        ana(12'h900, 1'b1);
        muxChanReq <= 3'h2;
        repeat (3) @(posedge ref_clk);
        check("muxFree", {28'h0, muxHold_q, muxChan_q}, 32'h2);
        check("pending", 32'(rdExp.size() + trExp.size()), 32'h0);
        finishTest;
    end
endmodule // tss_trigger_select_test
`default_nettype wire

// *** rtl/tss_defs.vh ***
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

// register byte offsets
`define TSS_OFF_DSEL 5'h00
`define TSS_OFF_ASEL 5'h04
`define TSS_OFF_LEVEL 5'h08
`define TSS_OFF_SCAN 5'h0c
`define TSS_OFF_ACTION 5'h10
`define TSS_OFF_ROUTE 5'h14
`define TSS_OFF_CMD 5'h18
`define TSS_OFF_STATUS 5'h1c

// digital source select fields
`define TSS_DSEL_SRC_LSB 0
`define TSS_DSEL_SRC_MSB 4
`define TSS_DSEL_FALL_BIT 8
`define TSS_DSEL_EN_BIT 9
`define TSS_SRC_STB_BASE 5'h10
`define TSS_SRC_STAR 5'h18

// analog source select fields
`define TSS_ASEL_SRC_LSB 0
`define TSS_ASEL_SRC_MSB 1
`define TSS_ASEL_CH_LSB 4
`define TSS_ASEL_CH_MSB 6
`define TSS_ASEL_MODE_LSB 8
`define TSS_ASEL_MODE_MSB 10
`define TSS_ASEL_KIND_LSB 12
`define TSS_ASEL_KIND_MSB 13
`define TSS_ASEL_EN_BIT 16

// analog sources, modes, trigger kinds
`define TSS_ASRC_TERM0 2'h0
`define TSS_ASRC_TERM1 2'h1
`define TSS_ASRC_AI 2'h2
`define TSS_MODE_BELOW 3'h0
`define TSS_MODE_ABOVE 3'h1
`define TSS_MODE_HYST_RISE 3'h2
`define TSS_MODE_HYST_FALL 3'h3
`define TSS_MODE_WIN_ENTER 3'h4
`define TSS_MODE_WIN_LEAVE 3'h5
`define TSS_KIND_START 2'h0
`define TSS_KIND_REF 2'h1
`define TSS_KIND_PAUSE 2'h2

// level register: level/top low half, hysteresis/bottom high half
`define TSS_LEVEL_HI_LSB 16

// scan register fields
`define TSS_SCAN_CNT_LSB 0
`define TSS_SCAN_CNT_MSB 3
`define TSS_SCAN_FIRST_LSB 8
`define TSS_SCAN_FIRST_MSB 10
`define TSS_SCAN_MASK_LSB 16

// action register: digital actions low, analog actions from bit 8
`define TSS_ACT_ANA_LSB 8

// route register: function lines low, bus lines from bit 16
`define TSS_ROUTE_STB_LSB 16

// command register bits
`define TSS_CMD_SWTRIG_BIT 0
`define TSS_CMD_CLEAR_BIT 1

// reset values
`define TSS_RST_DSEL 32'h0000_0000
`define TSS_RST_ASEL 32'h0000_0000
`define TSS_RST_SCAN 32'h0000_0001
`define TSS_RST_ACTION 32'h0000_0000
`define TSS_RST_ROUTE 32'h0000_0000

`endif

// *** rtl/tss_trigger_select.v ***
// Contract
// - The digital trigger comes from a chosen function, bus or star line.
// - The chosen line is watched for a rising or a falling transition.
// - A digital trigger acts on input, output, counter or waveform logic.
// - A software command issues a trigger through the same path.
// - The analog source is a function terminal or an input channel.
// - A multiplexed device holds the mux on the trigger channel.
// - A multiplexed start trigger channel must head the scan list.
// - A multiplexed reference or pause trigger needs a one-entry list.
// - A simultaneous device triggers on any channel in the scan list.
// - The comparison event acts on input, output and counter logic.
// - The comparison event can be routed to any function or bus line.
// - Below and above modes assert while under or over the level.
// - Hysteresis modes arm past one threshold, assert past the other.
// - Window mode asserts on entering or leaving the band.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tss_defs.vh"

module tss_trigger_select #(
    parameter SW = 12,
    parameter NCH = 8,
    parameter SIMUL = 0
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // register bus
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // trigger lines in
    input wire [15:0] pfLineIn,
    input wire [7:0] stbLineIn,
    input wire starTrigIn,
    // analog samples
    input wire [SW-1:0] afTerm0Sample,
    input wire [SW-1:0] afTerm1Sample,
    input wire [SW-1:0] pgaSample,
    input wire [NCH*SW-1:0] aiSimSamples,
    input wire [2:0] muxChanReq,
    // mux control
    output reg [2:0] muxChan_q,
    output reg muxHold_q,
    // digital trigger actions
    output reg aiTrig_q,
    output reg aoTrig_q,
    output reg ctrTrig_q,
    output reg dwaveTrig_q,
    // comparison event actions
    output reg cmpEvent_q,
    output reg [4:0] cmpAction_q,
    // routed outputs
    output reg [15:0] pfLineOut_q,
    output reg [15:0] pfLineOe_q,
    output reg [7:0] stbLineOut_q,
    output reg [7:0] stbLineOe_q
);

    // ********************************
    // register bus
    // ********************************
    reg [31:0] dsel_q;
    reg [31:0] asel_q;
    reg [SW-1:0] levelLo_q;
    reg [SW-1:0] levelHi_q;
    reg [31:0] scan_q;
    reg [31:0] action_q;
    reg [31:0] route_q;
    reg swPulse_q;
    reg digSeen_q;
    reg cmpSeen_q;
    reg waiting_q;
    reg cfgErr;
    reg digPulse;
    reg [31:0] rdMux;

    wire wrTake = avs_write && !avs_waitrequest;
    wire clrCmd = wrTake && avs_address == `TSS_OFF_CMD &&
        avs_writedata[`TSS_CMD_CLEAR_BIT];

    always @*
    begin
        case (avs_address)
            `TSS_OFF_DSEL: rdMux = dsel_q;
            `TSS_OFF_ASEL: rdMux = asel_q;
            `TSS_OFF_LEVEL: rdMux = {{(16-SW){1'b0}}, levelHi_q,
                {(16-SW){1'b0}}, levelLo_q};
            `TSS_OFF_SCAN: rdMux = scan_q;
            `TSS_OFF_ACTION: rdMux = action_q;
            `TSS_OFF_ROUTE: rdMux = route_q;
            `TSS_OFF_STATUS: rdMux = {27'h0, cmpSeen_q, digSeen_q,
                cfgErr, muxHold_q, cmpEvent_q};
            default: rdMux = 32'h0;
        endcase
    end

    // one wait cycle, then answer for exactly one edge
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else if ((avs_read || avs_write) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rdMux : 32'h0;
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            dsel_q <= `TSS_RST_DSEL;
            asel_q <= `TSS_RST_ASEL;
            levelLo_q <= {SW{1'b0}};
            levelHi_q <= {SW{1'b0}};
            scan_q <= `TSS_RST_SCAN;
            action_q <= `TSS_RST_ACTION;
            route_q <= `TSS_RST_ROUTE;
            swPulse_q <= 1'b0;
        end
        else
        begin
            swPulse_q <= wrTake && avs_address == `TSS_OFF_CMD &&
                avs_writedata[`TSS_CMD_SWTRIG_BIT];
            if (wrTake)
            begin
                case (avs_address)
                    `TSS_OFF_DSEL: dsel_q <= avs_writedata;
                    `TSS_OFF_ASEL: asel_q <= avs_writedata;
                    `TSS_OFF_LEVEL:
                    begin
                        levelLo_q <= avs_writedata[SW-1:0];
                        levelHi_q <= avs_writedata[`TSS_LEVEL_HI_LSB+SW-1:
                            `TSS_LEVEL_HI_LSB];
                    end
                    `TSS_OFF_SCAN: scan_q <= avs_writedata;
                    `TSS_OFF_ACTION: action_q <= avs_writedata;
                    `TSS_OFF_ROUTE: route_q <= avs_writedata;
                    default: ;
                endcase
            end
        end
    end

    // ********************************
    // digital trigger path
    // ********************************
    wire [24:0] linesRaw = {starTrigIn, stbLineIn, pfLineIn};
    reg [24:0] sync1_q;
    reg [24:0] sync2_q;
    reg selPrev_q;
    reg selNow;
    wire [4:0] dSrc = dsel_q[`TSS_DSEL_SRC_MSB:`TSS_DSEL_SRC_LSB];

    always @*
    begin
        if (dSrc <= `TSS_SRC_STAR)
            selNow = sync2_q[dSrc];
        else
            selNow = 1'b0;
        if (!dsel_q[`TSS_DSEL_EN_BIT])
            digPulse = 1'b0;
        else if (dsel_q[`TSS_DSEL_FALL_BIT])
            digPulse = selPrev_q && !selNow;
        else
            digPulse = !selPrev_q && selNow;
    end

    wire trigAny = digPulse || swPulse_q;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync1_q <= 25'h0;
            sync2_q <= 25'h0;
            selPrev_q <= 1'b0;
            aiTrig_q <= 1'b0;
            aoTrig_q <= 1'b0;
            ctrTrig_q <= 1'b0;
            dwaveTrig_q <= 1'b0;
            digSeen_q <= 1'b0;
        end
        else
        begin
            sync1_q <= linesRaw;
            sync2_q <= sync1_q;
            selPrev_q <= selNow;
            aiTrig_q <= trigAny && action_q[0];
            aoTrig_q <= trigAny && action_q[1];
            ctrTrig_q <= trigAny && action_q[2];
            dwaveTrig_q <= trigAny && action_q[3];
            if (trigAny)
                digSeen_q <= 1'b1;
            else if (clrCmd)
                digSeen_q <= 1'b0;
        end
    end

    // ********************************
    // analog source and scan checks
    // ********************************
    wire [1:0] aSrc = asel_q[`TSS_ASEL_SRC_MSB:`TSS_ASEL_SRC_LSB];
    wire [2:0] trigChan = asel_q[`TSS_ASEL_CH_MSB:`TSS_ASEL_CH_LSB];
    wire [2:0] aMode = asel_q[`TSS_ASEL_MODE_MSB:`TSS_ASEL_MODE_LSB];
    wire [1:0] aKind = asel_q[`TSS_ASEL_KIND_MSB:`TSS_ASEL_KIND_LSB];
    wire aEn = asel_q[`TSS_ASEL_EN_BIT];
    wire [3:0] scanCnt = scan_q[`TSS_SCAN_CNT_MSB:`TSS_SCAN_CNT_LSB];
    wire [2:0] scanFirst = scan_q[`TSS_SCAN_FIRST_MSB:`TSS_SCAN_FIRST_LSB];
    wire [NCH-1:0] scanMask = scan_q[`TSS_SCAN_MASK_LSB+NCH-1:
        `TSS_SCAN_MASK_LSB];
    reg [SW-1:0] sample;

    always @*
    begin
        case (aSrc)
            `TSS_ASRC_TERM0: sample = afTerm0Sample;
            `TSS_ASRC_TERM1: sample = afTerm1Sample;
            `TSS_ASRC_AI:
                if (SIMUL != 0)
                    sample = aiSimSamples[trigChan*SW +: SW];
                else
                    sample = pgaSample;
            default: sample = {SW{1'b0}};
        endcase
        cfgErr = 1'b0;
        if (aEn && aSrc == `TSS_ASRC_AI)
        begin
            if (SIMUL != 0)
                cfgErr = !scanMask[trigChan];
            else if (aKind == `TSS_KIND_START)
                cfgErr = scanFirst != trigChan;
            else
                cfgErr = scanCnt != 4'h1;
        end
    end

    // ********************************
    // comparator
    // ********************************
    function [SW-1:0] satSum;
        input [SW-1:0] a;
        input [SW-1:0] b;
        input sub;
        reg [SW:0] r;
        begin
            r = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
            if (r[SW])
                satSum = sub ? {SW{1'b0}} : {SW{1'b1}};
            else
                satSum = r[SW-1:0];
        end
    endfunction

    reg primed_q;
    reg cmp_d;
    reg primed_d;
    reg [SW-1:0] thrLo;
    reg [SW-1:0] thrHi;
    wire detOn = aEn && !cfgErr;

    always @*
    begin
        thrLo = levelLo_q;
        thrHi = levelLo_q;
        if (aMode == `TSS_MODE_HYST_RISE)
            thrLo = satSum(levelLo_q, levelHi_q, 1'b1);
        if (aMode == `TSS_MODE_HYST_FALL)
            thrHi = satSum(levelLo_q, levelHi_q, 1'b0);
        cmp_d = cmpEvent_q;
        primed_d = primed_q;
        case (aMode)
            `TSS_MODE_BELOW: cmp_d = sample < levelLo_q;
            `TSS_MODE_ABOVE: cmp_d = sample > levelLo_q;
            `TSS_MODE_HYST_RISE:
            begin
                if (sample < thrLo)
                begin
                    cmp_d = 1'b0;
                    primed_d = 1'b1;
                end
                else if (primed_q && sample > thrHi)
                begin
                    cmp_d = 1'b1;
                    primed_d = 1'b0;
                end
            end
            `TSS_MODE_HYST_FALL:
            begin
                if (sample > thrHi)
                begin
                    cmp_d = 1'b0;
                    primed_d = 1'b1;
                end
                else if (primed_q && sample < thrLo)
                begin
                    cmp_d = 1'b1;
                    primed_d = 1'b0;
                end
            end
            `TSS_MODE_WIN_ENTER:
                cmp_d = sample < levelLo_q && sample > levelHi_q;
            `TSS_MODE_WIN_LEAVE:
                cmp_d = !(sample < levelLo_q &&
                    sample > levelHi_q);
            default: cmp_d = 1'b0;
        endcase
        if (!detOn)
        begin
            cmp_d = 1'b0;
            primed_d = 1'b0;
        end
    end

    wire aselWr = wrTake && avs_address == `TSS_OFF_ASEL;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            cmpEvent_q <= 1'b0;
            primed_q <= 1'b0;
            cmpAction_q <= 5'h0;
            cmpSeen_q <= 1'b0;
            waiting_q <= 1'b0;
            muxHold_q <= 1'b0;
            muxChan_q <= 3'h0;
        end
        else
        begin
            cmpEvent_q <= cmp_d;
            primed_q <= primed_d;
            cmpAction_q <= {5{cmp_d}} &
                action_q[`TSS_ACT_ANA_LSB+4:`TSS_ACT_ANA_LSB];
            if (cmp_d)
                cmpSeen_q <= 1'b1;
            else if (clrCmd)
                cmpSeen_q <= 1'b0;
            if (aselWr)
                waiting_q <= avs_writedata[`TSS_ASEL_EN_BIT];
            else if (cmp_d || !detOn)
                waiting_q <= 1'b0;
            muxHold_q <= SIMUL == 0 && waiting_q && detOn &&
                aSrc == `TSS_ASRC_AI && !cmp_d;
            if (SIMUL == 0 && waiting_q && detOn && aSrc == `TSS_ASRC_AI)
                muxChan_q <= trigChan;
            else
                muxChan_q <= muxChanReq;
        end
    end

    // ********************************
    // event routing to lines
    // ********************************
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pfLineOut_q <= 16'h0;
            pfLineOe_q <= 16'h0;
            stbLineOut_q <= 8'h0;
            stbLineOe_q <= 8'h0;
        end
        else
        begin
            pfLineOut_q <= {16{cmp_d}};
            pfLineOe_q <= route_q[15:0];
            stbLineOut_q <= {8{cmp_d}};
            stbLineOe_q <= route_q[`TSS_ROUTE_STB_LSB+7:
                `TSS_ROUTE_STB_LSB];
        end
    end

endmodule // tss_trigger_select
`default_nettype wire
